/* dv/rgpl_monitor.sv */
// concurrent checks on the rgpl pins
`timescale 1ns/1ps
module rgpl_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // wake and sampling clock
    input wire logic wake_start,
    input wire logic osc_settled,
    input wire logic adc_clk_sel,
    input wire logic adc_sample_tick,
    // synthesiser lock
    input wire logic pll_lock_raw,
    input wire logic radio_in_tx,
    input wire logic pll_locked,
    input wire logic forced_radio_off,
    // gain control
    input wire logic gain_switch,
    input wire logic sync_found,
    input wire logic level_settle_busy,
    input wire logic gain_hold
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // cycles since last tick; a select change may bend one period, so skip it
    logic [6:0] gap;
    logic gap_ok;
    logic sel_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gap <= 7'h00;
            gap_ok <= 1'b0;
            sel_q <= 1'b0;
        end
        else
        begin
            gap <= adc_sample_tick ? 7'h00 : gap + 7'h01;
            gap_ok <= adc_sample_tick | (gap_ok & (adc_clk_sel == sel_q));
            sel_q <= adc_clk_sel;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_tick_gap; adc_sample_tick && gap_ok && adc_clk_sel == sel_q
        |-> gap == (adc_clk_sel ? 7'h31 : 7'h39); endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("sample tick period wrong");
    property p_wake_clear; wake_start |=> !osc_settled; endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("settled kept after wake");
    property p_unlock_now; pll_locked && !pll_lock_raw |=> !pll_locked; endproperty
    a_unlock_now: assert property (p_unlock_now) else $error("unlock not at once");
    property p_lock_high; $rose(pll_locked) |-> $past(pll_lock_raw) && $past(pll_lock_raw, 8);
    endproperty
    a_lock_high: assert property (p_lock_high) else $error("lock without raw high");
    property p_forced_cause; forced_radio_off
        |-> $past(radio_in_tx) && !$past(pll_locked) && $past(pll_locked, 2); endproperty
    a_forced_cause: assert property (p_forced_cause) else $error("forced off uncaused");
    property p_rx_keep; !radio_in_tx [*3] |-> !forced_radio_off; endproperty
    a_rx_keep: assert property (p_rx_keep) else $error("forced off outside transmit");
    property p_hold_sync; !$past(sync_found) |-> !gain_hold; endproperty
    a_hold_sync: assert property (p_hold_sync) else $error("gain held without sync");
    property p_settle_start; $rose(level_settle_busy) |-> $past(gain_switch); endproperty
    a_settle_start: assert property (p_settle_start) else $error("settle wait uncaused");
    // scenarios
    c_forced: cover property (forced_radio_off);
    c_lock: cover property ($rose(pll_locked));
    c_settled: cover property ($rose(osc_settled));
endmodule
bind rgpl_top rgpl_monitor mon (.*);

/* dv/testbench.sv */
// self-checking bench for rgpl
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [5:0] i; logic [7:0] w; logic [7:0] rs; logic [7:0] bk;
        logic [1:0] rp;} rgpl_row_t;
    localparam int WAITS [4] = '{40, 30, 20, 10};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    rgpl_pkg::rgpl_axi_req_t req = '0;
    rgpl_pkg::rgpl_axi_rsp_t rsp;
    logic wake_start = 1'b0, temp_sample_valid = 1'b0, temp_adc_route_en = 1'b0;
    logic radio_in_sleep = 1'b0, pll_lock_raw = 1'b0, radio_in_tx = 1'b0, radio_in_rx = 1'b0;
    logic gain_switch = 1'b0, sync_found = 1'b0;
    logic [7:0] temp_sample = 8'h00;
    logic [3:0] level_settle_wait = 4'h1;
    logic osc_wait_busy, osc_settled, adc_clk_sel, adc_sample_tick, pll_locked;
    logic forced_radio_off, level_settle_busy, gain_hold, irq;
    logic [5:0] t_ml, t_lm, t_hm, t_mh;
    logic [1:0] r;
    int n;
    int n_mismatch = 0;
    int n_tests = 0;
    // rows: index, write, reset value, readback, answer
    rgpl_row_t rows [10] = '{'{6'h08, 8'h70, 8'h50, 8'h70, 2'h0},
        '{6'h09, 8'h5a, 8'h00, 8'h5a, 2'h0}, '{6'h0a, 8'hff, 8'h00, 8'h00, 2'h0},
        '{6'h0b, 8'h80, 8'h81, 8'h80, 2'h0}, '{6'h0c, 8'h3f, 8'h1e, 8'h3f, 2'h0},
        '{6'h0d, 8'h01, 8'h02, 8'h01, 2'h0}, '{6'h0e, 8'ha5, 8'h9e, 8'ha5, 2'h0},
        '{6'h0f, 8'h00, 8'h02, 8'h00, 2'h0}, '{6'h21, 8'hff, 8'h00, 8'h03, 2'h0},
        '{6'h30, 8'h11, 8'h00, 8'h00, 2'h2}};
    // unlock rows: config, transmit, receive, mask, forced off, irq
    logic [13:0] lk [3] = '{{8'h80, 6'b101111}, {8'h80, 6'b011101}, {8'h01, 6'b100000}};
    rgpl_top #(.OSC_WAIT0_CYC(40), .OSC_WAIT1_CYC(30), .OSC_WAIT2_CYC(20), .OSC_WAIT3_CYC(10))
        dut (.*, .axi_req(req), .axi_rsp(rsp), .thresh_mid_to_low(t_ml),
        .thresh_low_to_mid(t_lm), .thresh_high_to_mid(t_hm), .thresh_mid_to_high(t_mh));
    always #5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d in %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // write: address and data together, bready held until the answer
    task automatic wr(input logic [5:0] i, input logic [7:0] d, output logic [1:0] rp);
        @(posedge aclk);
        req.awaddr <= {4'h0, i, 2'b00};
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1);
        rp = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    // read and compare data and answer
    task automatic rc(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        req.araddr <= {4'h0, i, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1);
        chk("rdata", {24'h0, e}, rsp.rdata);
        chk("rresp", er, rsp.rresp);
        req.rready <= 1'b0;
    endtask
    // count edges until a pin reaches a level
    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        do
        begin
            @(posedge aclk);
            #1;
            n++;
        end
        while (s !== v);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[k])
        begin
            rc(rows[k].i, rows[k].rs, rows[k].rp);
            wr(rows[k].i, rows[k].w, r);
            chk("bresp", rows[k].rp, r);
            rc(rows[k].i, rows[k].bk, rows[k].rp);
        end
        chk("thresholds", {6'h3f, 6'h01, 6'h25, 6'h00}, {t_ml, t_lm, t_hm, t_mh});
        for (int s = 0; s < 4; s++)
        begin
            wr(6'h08, {1'b0, 2'(s), s[0], 4'h0}, r);
            @(posedge aclk);
            wake_start <= 1'b1;
            @(posedge aclk);
            wake_start <= 1'b0;
            #1 chk("osc busy", 1, osc_wait_busy);
            wait_for(osc_settled, 1'b1);
            chk("osc wait", WAITS[s] + 1, n);
            chk("adc select", s[0], adc_clk_sel);
        end
        chk("irq", 1, irq);
        rc(6'h20, 8'h02, 2'h0);
        rc(6'h20, 8'h00, 2'h0);
        chk("irq", 0, irq);
        wr(6'h08, 8'h00, r);
        repeat (130) @(posedge aclk);
        for (int j = 0; j < 3; j++)
        begin
            wr(6'h0b, lk[j][13:6], r);
            wr(6'h21, {6'h00, lk[j][3:2]}, r);
            @(posedge aclk);
            radio_in_tx <= lk[j][5];
            radio_in_rx <= lk[j][4];
            pll_lock_raw <= 1'b1;
            wait_for(pll_locked, 1'b1);
            chk("lock delay", 32'(lk[j][12:6]) * 800 + 101, n);
            @(posedge aclk);
            pll_lock_raw <= 1'b0;
            repeat (2) @(posedge aclk);
            #1;
            chk("forced off", lk[j][1], forced_radio_off);
            chk("irq", lk[j][0], irq);
            rc(6'h20, 8'h01, 2'h0);
        end
        for (int j = 0; j < 3; j++)
        begin
            @(posedge aclk);
            temp_adc_route_en <= (j != 1);
            radio_in_sleep <= (j == 2);
            temp_sample <= 8'h31 + 8'(j);
            temp_sample_valid <= 1'b1;
            @(posedge aclk);
            temp_sample_valid <= 1'b0;
            rc(6'h09, 8'h31, 2'h0);
        end
        @(posedge aclk);
        sync_found <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("gain hold", 1, gain_hold);
        wr(6'h0e, 8'h25, r);
        repeat (2) @(posedge aclk);
        #1;
        chk("gain hold", 0, gain_hold);
        wr(6'h08, 8'h10, r);
        @(posedge aclk);
        gain_switch <= 1'b1;
        @(posedge aclk);
        gain_switch <= 1'b0;
        wait_for(level_settle_busy, 1'b0);
        chk("settle span", 1, n > 50 && n <= 101);
        // mid-run reset restores reset values
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc(6'h0c, 8'h1e, 2'h0);
        chk("adc select", 1, adc_clk_sel);
        test_done;
    end
    // watchdog well past the longest run
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        test_done;
    end
endmodule

/* verilog/rgpl_lock_detect.sv */
// turns the raw lock indicator into a declared lock
`timescale 1ns/1ps
module rgpl_lock_detect (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // raw indicator and window setting
    input wire logic lock_raw,
    input wire logic [6:0] lock_detect_window,
    // declared state
    output logic locked,
    output logic unlock_evt
);
    typedef struct packed {
        logic [16:0] cnt;
        logic locked;
        logic unlock_evt;
    } rgpl_ld_st_t;

    rgpl_ld_st_t st;
    rgpl_ld_st_t next_st;
    logic [16:0] window_cyc;

    // window length in cycles; 127 * 800 + 100 still fits 17 bits
    assign window_cyc = 17'(lock_detect_window) * rgpl_pkg::LD_STEP_CYC
        + rgpl_pkg::LD_BASE_CYC;

    // lock needs a high run longer than the window, any low drops it at once
    always_comb
    begin
        next_st = st;
        next_st.unlock_evt = 1'b0;
        if (!lock_raw)
        begin
            next_st.cnt = '0;
            next_st.locked = 1'b0;
            next_st.unlock_evt = st.locked;
        end
        else if (!st.locked)
        begin
            next_st.cnt = st.cnt + 17'h1;
            if (next_st.cnt > window_cyc)
                next_st.locked = 1'b1;
        end
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '{cnt: '0, locked: 1'b0, unlock_evt: 1'b0};
        else
            st <= next_st;
    end

    assign locked = st.locked;
    assign unlock_evt = st.unlock_evt;
endmodule

/* verilog/rgpl_pkg.sv */
// constants and carrier types of the rgpl register group
package rgpl_pkg;
    // clock and time base
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned OSC_WAIT0_CYC = 500 * CLK_MHZ;
    localparam int unsigned OSC_WAIT1_CYC = 250 * CLK_MHZ;
    localparam int unsigned OSC_WAIT2_CYC = 50 * CLK_MHZ;
    localparam int unsigned OSC_WAIT3_CYC = 10 * CLK_MHZ;
    localparam int unsigned OSC_CNT_W = 17;
    // sampling dividers for 2000 and 1730 kHz, rounded to nearest cycle
    localparam logic [6:0] ADC_FAST_DIV = 7'((CLK_MHZ * 1000 + 1000) / 2000);
    localparam logic [6:0] ADC_SLOW_DIV = 7'((CLK_MHZ * 1000 + 865) / 1730);
    // lock detection window: setting * 8 us + 1 us
    localparam logic [16:0] LD_STEP_CYC = 17'(8 * CLK_MHZ);
    localparam logic [16:0] LD_BASE_CYC = 17'(1 * CLK_MHZ);
    // register indexes; byte address is four times the index
    localparam logic [5:0] IDX_ADC_CLOCK_AND_OSC_WAIT = 6'h08;
    localparam logic [5:0] IDX_THERMAL_READING = 6'h09;
    localparam logic [5:0] IDX_RESERVED_0A = 6'h0a;
    localparam logic [5:0] IDX_SYNTH_LOCK_DETECT_CFG = 6'h0b;
    localparam logic [5:0] IDX_GAIN_MID_TO_LOW = 6'h0c;
    localparam logic [5:0] IDX_GAIN_LOW_TO_MID = 6'h0d;
    localparam logic [5:0] IDX_GAIN_HIGH_TO_MID = 6'h0e;
    localparam logic [5:0] IDX_GAIN_MID_TO_HIGH = 6'h0f;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
    localparam logic [5:0] IDX_LIVE_STATUS = 6'h22;
    // reset values
    localparam logic [7:0] RST_ADC_CLOCK_AND_OSC_WAIT = 8'h50;
    localparam logic [7:0] RST_THERMAL_READING = 8'h00;
    localparam logic [7:0] RST_SYNTH_LOCK_DETECT_CFG = 8'h81;
    localparam logic [7:0] RST_GAIN_MID_TO_LOW = 8'h1e;
    localparam logic [7:0] RST_GAIN_LOW_TO_MID = 8'h02;
    localparam logic [7:0] RST_GAIN_HIGH_TO_MID = 8'h9e;
    localparam logic [7:0] RST_GAIN_MID_TO_HIGH = 8'h02;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    // field positions
    localparam int unsigned POS_OSC_SEL = 5;
    localparam int unsigned POS_ADC_SEL = 4;
    localparam int unsigned POS_UNLOCK_STOP = 7;
    localparam int unsigned POS_GAIN_FREEZE = 7;
    localparam int unsigned POS_IRQ_UNLOCK = 0;
    localparam int unsigned POS_IRQ_OSC = 1;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned AXI_AW = 12;

    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AXI_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } rgpl_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rgpl_axi_rsp_t;
endpackage

/* verilog/rgpl_top.sv */
// clock wait, ADC clock, temperature, lock detect and gain threshold bank
//
// Contract
// - wake wait of 500/250/50/10 us by field
// - sampling clock 1.73 or 2.0 MHz, 2.0 default
// - temperature updates outside sleep when routing set
// - unlock in transmit: interrupt, optional forced off
// - unlock in receive: interrupt, stay receiving
// - lock window is setting times 8us plus 1us
// - lock after long high, unlock on any low
// - four 6-bit gain thresholds, bits 5:0
// - freeze bit holds gain once sync found
// - level settle wait is (setting+1) ADC periods
`timescale 1ns/1ps
module rgpl_top #(
    parameter int unsigned OSC_WAIT0_CYC = rgpl_pkg::OSC_WAIT0_CYC,
    parameter int unsigned OSC_WAIT1_CYC = rgpl_pkg::OSC_WAIT1_CYC,
    parameter int unsigned OSC_WAIT2_CYC = rgpl_pkg::OSC_WAIT2_CYC,
    parameter int unsigned OSC_WAIT3_CYC = rgpl_pkg::OSC_WAIT3_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire rgpl_pkg::rgpl_axi_req_t axi_req,
    output rgpl_pkg::rgpl_axi_rsp_t axi_rsp,
    // oscillator wait
    input wire logic wake_start,
    output logic osc_wait_busy,
    output logic osc_settled,
    // level ADC clock
    output logic adc_clk_sel,
    output logic adc_sample_tick,
    // temperature
    input wire logic temp_sample_valid,
    input wire logic [7:0] temp_sample,
    input wire logic temp_adc_route_en,
    input wire logic radio_in_sleep,
    // synthesiser lock
    input wire logic pll_lock_raw,
    input wire logic radio_in_tx,
    input wire logic radio_in_rx,
    output logic pll_locked,
    output logic forced_radio_off,
    // gain control
    input wire logic gain_switch,
    input wire logic [3:0] level_settle_wait,
    input wire logic sync_found,
    output logic level_settle_busy,
    output logic gain_hold,
    output logic [5:0] thresh_mid_to_low,
    output logic [5:0] thresh_low_to_mid,
    output logic [5:0] thresh_high_to_mid,
    output logic [5:0] thresh_mid_to_high,
    // interrupt
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_held;
        logic w_held;
        logic [5:0] aw_idx;
        logic [7:0] wbyte;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] adc_osc;
        logic [7:0] thermal;
        logic [7:0] lock_cfg;
        logic [7:0] mtol;
        logic [7:0] ltom;
        logic [7:0] htom;
        logic [7:0] mtoh;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic irq;
        logic settled;
        logic [6:0] adc_div;
        logic adc_tick;
        logic forced_off;
        logic gain_hold;
    } rgpl_top_st_t;

    rgpl_top_st_t st;
    rgpl_top_st_t next_st;

    logic osc_done;
    logic osc_busy;
    logic settle_busy;
    logic lock_now;
    logic unlock_evt;
    logic [rgpl_pkg::OSC_CNT_W-1:0] osc_load;
    logic [4:0] settle_load;

    // word index of a byte address
    function automatic logic [5:0] reg_index(input logic [rgpl_pkg::AXI_AW-1:0] addr);
        reg_index = addr[7:2];
    endfunction

    // true for every index that answers OKAY
    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx >= rgpl_pkg::IDX_ADC_CLOCK_AND_OSC_WAIT
            && idx <= rgpl_pkg::IDX_GAIN_MID_TO_HIGH)
            || idx == rgpl_pkg::IDX_IRQ_STATUS || idx == rgpl_pkg::IDX_IRQ_MASK
            || idx == rgpl_pkg::IDX_LIVE_STATUS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // wait selection from the two-bit field
    always_comb
    begin
        unique case (st.adc_osc[rgpl_pkg::POS_OSC_SEL +: 2])
            2'h0: osc_load = rgpl_pkg::OSC_CNT_W'(OSC_WAIT0_CYC);
            2'h1: osc_load = rgpl_pkg::OSC_CNT_W'(OSC_WAIT1_CYC);
            2'h2: osc_load = rgpl_pkg::OSC_CNT_W'(OSC_WAIT2_CYC);
            2'h3: osc_load = rgpl_pkg::OSC_CNT_W'(OSC_WAIT3_CYC);
        endcase
    end

    // settle wait counts ADC periods, one more than the setting
    assign settle_load = {1'b0, level_settle_wait} + 5'h1;

    rgpl_wait_timer #(
        .W(rgpl_pkg::OSC_CNT_W)
    ) u_osc_wait (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(wake_start),
        .load(osc_load),
        .tick(1'b1),
        .busy(osc_busy),
        .done(osc_done)
    );

    rgpl_wait_timer #(
        .W(5)
    ) u_level_settle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(gain_switch),
        .load(settle_load),
        .tick(st.adc_tick),
        .busy(settle_busy),
        .done()
    );

    rgpl_lock_detect u_lock (
        .aclk(aclk),
        .aresetn(aresetn),
        .lock_raw(pll_lock_raw),
        .lock_detect_window(st.lock_cfg[6:0]),
        .locked(lock_now),
        .unlock_evt(unlock_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave, register file and event logic
    always_comb
    begin
        logic [5:0] ridx;
        logic [7:0] rbyte;
        logic [1:0] clr;
        logic [1:0] set;
        logic [6:0] div_max;
        ridx = reg_index(axi_req.araddr);
        rbyte = 8'h00;
        clr = 2'h0;
        set = 2'h0;
        div_max = 7'h00;
        next_st = st;

        // write address and data may arrive in either order
        if (axi_req.awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = reg_index(axi_req.awaddr);
        end
        if (axi_req.wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wbyte = axi_req.wdata[7:0];
            next_st.wlane = axi_req.wstrb[0];
        end
        if (st.bvalid && axi_req.bready)
            next_st.bvalid = 1'b0;

        // commit once both halves are held and no answer is pending
        if (st.aw_held && st.w_held && !st.bvalid)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = idx_mapped(st.aw_idx) ? rgpl_pkg::RESP_OKAY : rgpl_pkg::RESP_SLVERR;
            if (st.wlane)
            begin
                unique case (st.aw_idx)
                    rgpl_pkg::IDX_ADC_CLOCK_AND_OSC_WAIT: next_st.adc_osc = st.wbyte;
                    rgpl_pkg::IDX_THERMAL_READING: next_st.thermal = st.wbyte;
                    rgpl_pkg::IDX_SYNTH_LOCK_DETECT_CFG: next_st.lock_cfg = st.wbyte;
                    rgpl_pkg::IDX_GAIN_MID_TO_LOW: next_st.mtol = st.wbyte;
                    rgpl_pkg::IDX_GAIN_LOW_TO_MID: next_st.ltom = st.wbyte;
                    rgpl_pkg::IDX_GAIN_HIGH_TO_MID: next_st.htom = st.wbyte;
                    rgpl_pkg::IDX_GAIN_MID_TO_HIGH: next_st.mtoh = st.wbyte;
                    rgpl_pkg::IDX_IRQ_MASK: next_st.irq_mask = st.wbyte[1:0];
                    default: next_st.bresp = next_st.bresp;
                endcase
            end
        end

        // read: one cycle to the answer, status cleared by the read itself
        if (st.rvalid && axi_req.rready)
            next_st.rvalid = 1'b0;
        if (axi_req.arvalid && st.arready)
        begin
            unique case (ridx)
                rgpl_pkg::IDX_ADC_CLOCK_AND_OSC_WAIT: rbyte = st.adc_osc;
                rgpl_pkg::IDX_THERMAL_READING: rbyte = st.thermal;
                rgpl_pkg::IDX_SYNTH_LOCK_DETECT_CFG: rbyte = st.lock_cfg;
                rgpl_pkg::IDX_GAIN_MID_TO_LOW: rbyte = st.mtol;
                rgpl_pkg::IDX_GAIN_LOW_TO_MID: rbyte = st.ltom;
                rgpl_pkg::IDX_GAIN_HIGH_TO_MID: rbyte = st.htom;
                rgpl_pkg::IDX_GAIN_MID_TO_HIGH: rbyte = st.mtoh;
                rgpl_pkg::IDX_IRQ_STATUS:
                begin
                    rbyte = {6'h00, st.irq_status};
                    clr = st.irq_status;
                end
                rgpl_pkg::IDX_IRQ_MASK: rbyte = {6'h00, st.irq_mask};
                rgpl_pkg::IDX_LIVE_STATUS:
                    rbyte = {4'h0, settle_busy, osc_busy, st.settled, lock_now};
                default: rbyte = 8'h00;
            endcase
            next_st.rvalid = 1'b1;
            next_st.rdata = {24'h000000, rbyte};
            next_st.rresp = idx_mapped(ridx) ? rgpl_pkg::RESP_OKAY : rgpl_pkg::RESP_SLVERR;
        end

        // ready flags are registered so the bus outputs come from flops
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;

        // temperature capture beats a software write in the same cycle
        if (temp_sample_valid && temp_adc_route_en && !radio_in_sleep)
            next_st.thermal = temp_sample;

        // unlock flags in either radio direction; receive is never stopped here
        if (unlock_evt && (radio_in_tx || radio_in_rx))
            set[rgpl_pkg::POS_IRQ_UNLOCK] = 1'b1;
        if (osc_done)
            set[rgpl_pkg::POS_IRQ_OSC] = 1'b1;
        // set wins over the read clear so no event is lost
        next_st.irq_status = (st.irq_status & ~clr) | set;
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);

        // stop transmit only when the stop bit is set
        next_st.forced_off = unlock_evt && radio_in_tx
            && st.lock_cfg[rgpl_pkg::POS_UNLOCK_STOP];

        // settled drops on wake, rises when the wait ends
        if (wake_start)
            next_st.settled = 1'b0;
        else if (osc_done)
            next_st.settled = 1'b1;

        // sampling tick divider; a rate change applies at once, to the period in progress
        div_max = st.adc_osc[rgpl_pkg::POS_ADC_SEL] ? rgpl_pkg::ADC_FAST_DIV
            : rgpl_pkg::ADC_SLOW_DIV;
        if (st.adc_div >= div_max - 7'h1)
        begin
            next_st.adc_div = 7'h00;
            next_st.adc_tick = 1'b1;
        end
        else
        begin
            next_st.adc_div = st.adc_div + 7'h1;
            next_st.adc_tick = 1'b0;
        end

        // freeze only while sync is held; cleared bit keeps gain adapting
        next_st.gain_hold = st.htom[rgpl_pkg::POS_GAIN_FREEZE] && sync_found;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.adc_osc <= rgpl_pkg::RST_ADC_CLOCK_AND_OSC_WAIT;
            st.thermal <= rgpl_pkg::RST_THERMAL_READING;
            st.lock_cfg <= rgpl_pkg::RST_SYNTH_LOCK_DETECT_CFG;
            st.mtol <= rgpl_pkg::RST_GAIN_MID_TO_LOW;
            st.ltom <= rgpl_pkg::RST_GAIN_LOW_TO_MID;
            st.htom <= rgpl_pkg::RST_GAIN_HIGH_TO_MID;
            st.mtoh <= rgpl_pkg::RST_GAIN_MID_TO_HIGH;
            st.irq_mask <= rgpl_pkg::RST_IRQ_MASK;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign axi_rsp.awready = st.awready;
    assign axi_rsp.wready = st.wready;
    assign axi_rsp.bvalid = st.bvalid;
    assign axi_rsp.bresp = st.bresp;
    assign axi_rsp.arready = st.arready;
    assign axi_rsp.rvalid = st.rvalid;
    assign axi_rsp.rdata = st.rdata;
    assign axi_rsp.rresp = st.rresp;
    assign osc_wait_busy = osc_busy;
    assign osc_settled = st.settled;
    assign adc_clk_sel = st.adc_osc[rgpl_pkg::POS_ADC_SEL];
    assign adc_sample_tick = st.adc_tick;
    assign pll_locked = lock_now;
    assign forced_radio_off = st.forced_off;
    assign level_settle_busy = settle_busy;
    assign gain_hold = st.gain_hold;
    assign thresh_mid_to_low = st.mtol[5:0];
    assign thresh_low_to_mid = st.ltom[5:0];
    assign thresh_high_to_mid = st.htom[5:0];
    assign thresh_mid_to_high = st.mtoh[5:0];
    assign irq = st.irq;
endmodule

/* verilog/rgpl_wait_timer.sv */
// down-counter timing a wait in enable pulses
`timescale 1ns/1ps
module rgpl_wait_timer #(
    parameter int unsigned W = 17
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic start,
    input wire logic [W-1:0] load,
    input wire logic tick,
    // status
    output logic busy,
    output logic done
);
    typedef enum logic {TM_IDLE, TM_RUN} rgpl_tm_state_t;
    typedef struct packed {
        rgpl_tm_state_t fsm;
        logic [W-1:0] cnt;
        logic done;
    } rgpl_tm_st_t;

    rgpl_tm_st_t st;
    rgpl_tm_st_t next_st;

    // a new start restarts the wait even when one is running
    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        if (start)
        begin
            next_st.fsm = TM_RUN;
            next_st.cnt = load;
        end
        else
        begin
            unique case (st.fsm)
                TM_IDLE: next_st.cnt = st.cnt;
                TM_RUN:
                begin
                    if (tick)
                    begin
                        if (st.cnt <= W'(1))
                        begin
                            next_st.fsm = TM_IDLE;
                            next_st.done = 1'b1;
                        end
                        next_st.cnt = st.cnt - W'(1);
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '{fsm: TM_IDLE, cnt: '0, done: 1'b0};
        else
            st <= next_st;
    end

    assign busy = (st.fsm == TM_RUN);
    assign done = st.done;
endmodule
